// [rtl/agc_pkg.sv]
// Constants and types for the gain correction and low limit block
`default_nettype none
package agc_pkg;
  localparam int DATA_W = 24;
  localparam logic [7:0] OFS_GAIN8 = 8'h1B;
  localparam logic [7:0] OFS_GAIN16 = 8'h1C;
  localparam logic [7:0] OFS_GAIN32 = 8'h1D;
  localparam logic [7:0] OFS_GAIN64 = 8'h1E;
  localparam logic [7:0] OFS_GAIN128 = 8'h1F;
  localparam logic [7:0] OFS_LOW_LIMIT = 8'h20;
  localparam logic [23:0] RST_GAIN = 24'h800000;
  localparam logic [23:0] RST_LIMIT = 24'h000000;
  localparam logic [2:0] GAIN_SEL_8 = 3'h3;
  localparam int NUM_GAIN = 5;
  localparam int FRAC_BITS = 23;
  // Register access request from the serial port decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [23:0] wdata;
  } agc_req_type;
  // Calibration engine overwrite of one correction word
  typedef struct packed {
    logic load;
    logic [2:0] gain_sel;
    logic [23:0] word;
  } agc_cal_type;
endpackage
`default_nettype wire

// [rtl/agc_gain_limit.sv]
// Gain correction bank, gain scaling and result0 under-range compare
`default_nettype none
module agc_gain_limit
  import agc_pkg::*;
(
  input wire logic clk, // 100 MHz core clock
  input wire logic rst_n, // Async reset, active low
  input wire agc_req_type req, // Register access from serial port
  input wire agc_cal_type cal, // Calibration overwrite
  input wire logic [2:0] gain_sel, // Active amplifier gain code
  input wire logic [23:0] conv_word, // Offset-corrected signed result
  input wire logic conv_valid, // Result pulse
  input wire logic [23:0] result0_word, // First result register
  input wire logic result0_valid, // Result0 completed pulse
  input wire logic polarity_select, // 1 = unipolar
  input wire logic format_offset, // 1 = offset binary output format
  output logic [23:0] rdata, // Read data
  output logic rvalid, // Read data valid pulse
  output logic [23:0] scaled_word, // Gain-corrected result
  output logic scaled_valid, // Scaled result pulse
  output logic result0_under_flag // Under-range status
);
  logic [23:0] gain_reg [NUM_GAIN];
  logic [23:0] gain_next [NUM_GAIN];
  logic [23:0] limit_reg, limit_next;
  logic [23:0] rdata_next, scaled_next;
  logic rvalid_next, scaled_valid_next, flag_reg, flag_next;
  logic [2:0] gidx;
  logic [47:0] prod;
  logic signed [24:0] cmp_res, cmp_lim;

  ////////////////////////////////////////////////////////////////////////
  // Correction words: host writes, calibration overwrites take priority
  genvar g;
  generate
    for (g = 0; g < NUM_GAIN; g++) begin : g_gain
      always_comb begin
        gain_next[g] = gain_reg[g]; // Holds otherwise
        if (req.wr && req.addr == OFS_GAIN8 + 8'(g)) begin
          gain_next[g] = req.wdata;
        end
        if (cal.load && cal.gain_sel == GAIN_SEL_8 + 3'(g)) begin
          gain_next[g] = cal.word;
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          gain_reg[g] <= RST_GAIN;
        end else begin
          gain_reg[g] <= gain_next[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Scaling path; gain codes below 3 (GAIN_SEL_8) belong to another bank and pass through
  always_comb begin
    gidx = 3'h0; // Keeps the index in range for pass-through codes
    if (gain_sel >= GAIN_SEL_8) begin
      gidx = 3'(gain_sel - GAIN_SEL_8);
    end
    // Unsigned word, one integer bit: shift drops the 23 fraction bits
    prod = 48'($signed(conv_word) * $signed({1'b0, gain_reg[gidx]}));
    scaled_next = scaled_word;
    scaled_valid_next = conv_valid;
    if (conv_valid) begin
      if (gain_sel >= GAIN_SEL_8) begin
        scaled_next = prod[FRAC_BITS +: DATA_W];
      end else begin
        scaled_next = conv_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads and low limit write
  always_comb begin
    limit_next = limit_reg;
    if (req.wr && req.addr == OFS_LOW_LIMIT) begin
      limit_next = req.wdata;
    end
    rvalid_next = req.rd;
    rdata_next = 24'h000000; // Unmapped offsets read zero
    if (req.rd) begin
      if (req.addr >= OFS_GAIN8 && req.addr <= OFS_GAIN128) begin
        rdata_next = gain_reg[3'(req.addr - OFS_GAIN8)];
      end else if (req.addr == OFS_LOW_LIMIT) begin
        rdata_next = limit_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare in the active representation; unipolar offset data is unsigned
  always_comb begin
    // Bipolar two's complement is signed; all others compare unsigned
    if (!polarity_select && !format_offset) begin
      cmp_res = {result0_word[23], result0_word};
      cmp_lim = {limit_reg[23], limit_reg};
    end else begin
      cmp_res = {1'b0, result0_word};
      cmp_lim = {1'b0, limit_reg};
    end
    flag_next = flag_reg;
    if (result0_valid) begin
      flag_next = cmp_res < cmp_lim;
    end
  end

  // Output and state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_reg <= RST_LIMIT;
      rdata <= 24'h000000;
      rvalid <= 1'b0;
      scaled_word <= 24'h000000;
      scaled_valid <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      limit_reg <= limit_next;
      rdata <= rdata_next;
      rvalid <= rvalid_next;
      scaled_word <= scaled_next;
      scaled_valid <= scaled_valid_next;
      flag_reg <= flag_next;
    end
  end
  assign result0_under_flag = flag_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_gain8_wr;
    @(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == OFS_GAIN8 && !cal.load)
      |=> gain_reg[0] == $past(req.wdata);
  endproperty
  a_gain8_wr: assert property (p_gain8_wr)
    else $error("gain8 word not written");
  property p_gain128_wr;
    @(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == OFS_GAIN128 && !cal.load)
      |=> gain_reg[4] == $past(req.wdata);
  endproperty
  a_gain128_wr: assert property (p_gain128_wr)
    else $error("gain128 word not written");
  sequence s_write_lim;
    req.wr && req.addr == OFS_LOW_LIMIT;
  endsequence
  sequence s_read_lim;
    req.rd && req.addr == OFS_LOW_LIMIT && !req.wr;
  endsequence
  property p_limit_rw;
    @(posedge clk) disable iff (!rst_n)
    s_write_lim ##1 s_read_lim |=> rvalid && rdata == $past(req.wdata, 2);
  endproperty
  a_limit_rw: assert property (p_limit_rw)
    else $error("low limit readback mismatch");
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    (!req.wr && !cal.load) |=> $stable(gain_reg[2]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("gain32 word changed without cause");
  property p_flag_signed;
    @(posedge clk) disable iff (!rst_n)
    (result0_valid && !polarity_select && !format_offset)
      |=> result0_under_flag ==
          ($signed($past(result0_word)) < $signed($past(limit_reg)));
  endproperty
  a_flag_signed: assert property (p_flag_signed)
    else $error("signed under-range compare wrong");
  property p_flag_unsigned;
    @(posedge clk) disable iff (!rst_n)
    (result0_valid && (polarity_select || format_offset))
      |=> result0_under_flag == ($past(result0_word) < $past(limit_reg));
  endproperty
  a_flag_unsigned: assert property (p_flag_unsigned)
    else $error("unsigned under-range compare wrong");
  property p_flag_hold;
    @(posedge clk) disable iff (!rst_n)
    !result0_valid |=> $stable(result0_under_flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag moved without a result");
  property p_unity;
    @(posedge clk) disable iff (!rst_n)
    (conv_valid && gain_sel == GAIN_SEL_8 && gain_reg[0] == 24'h800000)
      |=> scaled_valid && scaled_word == $past(conv_word);
  endproperty
  a_unity: assert property (p_unity)
    else $error("unity gain word did not pass result");
  property p_zero;
    @(posedge clk) disable iff (!rst_n)
    (conv_valid && gain_sel >= GAIN_SEL_8 && gain_reg[gidx] == 24'h000000)
      |=> scaled_word == 24'h000000;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero gain word did not zero result");
  property p_gain16_wr;
    @(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == OFS_GAIN16 && !cal.load)
      |=> gain_reg[1] == $past(req.wdata);
  endproperty
  a_gain16_wr: assert property (p_gain16_wr)
    else $error("gain16 word not written");
  property p_gain32_wr;
    @(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == OFS_GAIN32 && !cal.load)
      |=> gain_reg[2] == $past(req.wdata);
  endproperty
  a_gain32_wr: assert property (p_gain32_wr)
    else $error("gain32 word not written");
  property p_gain64_wr;
    @(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == OFS_GAIN64 && !cal.load)
      |=> gain_reg[3] == $past(req.wdata);
  endproperty
  a_gain64_wr: assert property (p_gain64_wr)
    else $error("gain64 word not written");
  property p_cal_wins;
    @(posedge clk) disable iff (!rst_n)
    (cal.load && cal.gain_sel == GAIN_SEL_8 + 3'h3)
      |=> gain_reg[3] == $past(cal.word);
  endproperty
  a_cal_wins: assert property (p_cal_wins)
    else $error("calibration word not taken for gain64");
  property p_pass_low;
    @(posedge clk) disable iff (!rst_n)
    (conv_valid && gain_sel < GAIN_SEL_8)
      |=> scaled_valid && scaled_word == $past(conv_word);
  endproperty
  a_pass_low: assert property (p_pass_low)
    else $error("low gain result not passed through");
endmodule
`default_nettype wire

// [verification/agc_host_model.sv]
// Host software model issuing register accesses
`default_nettype none
module agc_host_model
  import agc_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic [23:0] rdata, // Read data
  input wire logic rvalid, // Read data valid
  output var agc_req_type req // Register request
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  // One access; strobe held until the taking edge, answer read after it
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [23:0] d, output logic [24:0] q);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    q = {rvalid, rdata};
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Write then read in the very next cycle, no idle gap between them
  task automatic write_read(input logic [7:0] a, input logic [23:0] d,
                            output logic [24:0] q);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    #1;
    q = {rvalid, rdata};
    req.rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// [verification/agc_gain_limit_tb.sv]
// Self-checking bench for the gain correction and low limit block
`default_nettype none
module agc_gain_limit_tb
  import agc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
  logic clk = 0, rst_n = 0, conv_valid = 0, result0_valid = 0, eb;
  logic polarity_select = 0, format_offset = 0, rvalid, scaled_valid, flag;
  logic [2:0] gain_sel = 0;
  logic [23:0] conv_word = 0, result0_word = 0, rdata, scaled_word, v, e;
  logic [23:0] gw [7];
  logic [24:0] got;
  logic [31:0] lfsr = 32'h3126;
  agc_req_type req;
  agc_cal_type cal = '0;
  int n_errors = 0, n_checks = 0, cyc = 0;
  // Repeatable pseudo-random words
  function automatic logic [23:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[23:0];
  endfunction
  // Signed result times unsigned word with 23 fraction bits
  function automatic logic [23:0] scale(logic [23:0] c, logic [23:0] g);
    logic signed [48:0] p;
    p = $signed(c) * $signed({1'b0, g});
    return p[46:23];
  endfunction
  // Signed compare only for bipolar two's complement
  function automatic logic under(logic [23:0] r, logic [23:0] l,
                                 logic pol, logic fmt);
    return (!pol && !fmt) ? ($signed(r) < $signed(l)) : (r < l);
  endfunction
  agc_host_model host_inst (.clk(clk), .rdata(rdata), .rvalid(rvalid),
    .req(req));
  agc_gain_limit agc_gain_limit_inst (.clk(clk), .rst_n(rst_n), .req(req),
    .cal(cal), .gain_sel(gain_sel), .conv_word(conv_word),
    .conv_valid(conv_valid), .result0_word(result0_word),
    .result0_valid(result0_valid), .polarity_select(polarity_select),
    .format_offset(format_offset), .rdata(rdata), .rvalid(rvalid),
    .scaled_word(scaled_word), .scaled_valid(scaled_valid),
    .result0_under_flag(flag));
  // Counts, verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: registers, calibration, scaling, under-range flag
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1;
    for (int i = 0; i < 7; i++) begin
      host_inst.access(1'b0, 8'(OFS_GAIN8 + i), 24'h0, got);
      `CHK("reset", {1'b1, i < 5 ? RST_GAIN : 24'h0}, got)
      gw[i] = rnd();
      host_inst.access(1'b1, 8'(OFS_GAIN8 + i), gw[i], got);
      host_inst.access(1'b0, 8'(OFS_GAIN8 + i), 24'h0, got);
      `CHK("rw", {1'b1, i < 6 ? gw[i] : 24'h0}, got)
    end
    for (int i = 0; i < 5; i++) begin
      gw[i] = rnd();
      cal <= '{1'b1, 3'(GAIN_SEL_8 + i), gw[i]};
      @(posedge clk);
      #1;
      cal.load <= 1'b0;
      host_inst.access(1'b0, 8'(OFS_GAIN8 + i), 24'h0, got);
      `CHK("cal", {1'b1, gw[i]}, got)
    end
    for (int k = 0; k < 24; k++) begin
      v = rnd();
      e = v;
      if (k % 8 >= 3)
        e = scale(v, gw[k % 8 - 3]);
      gain_sel <= 3'(k);
      conv_word <= v;
      conv_valid <= 1'b1;
      @(posedge clk);
      #1;
      `CHK("scaled", {1'b1, e}, {scaled_valid, scaled_word})
      conv_valid <= 1'b0;
      @(posedge clk);
      #1;
    end
    for (int k = 0; k < 32; k++) begin
      polarity_select <= k[0];
      format_offset <= k[1];
      gw[5] = rnd();
      host_inst.access(1'b1, OFS_LOW_LIMIT, gw[5], got);
      v = k[2] ? gw[5] : rnd();
      eb = under(v, gw[5], k[0], k[1]);
      result0_word <= v;
      result0_valid <= 1'b1;
      @(posedge clk);
      #1;
      `CHK("flag", eb, flag)
      result0_valid <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("hold", eb, flag)
    end
    // Corners: back-to-back access, mid-run reset, unity and zero words,
    // calibration colliding with a host write to the same word
    v = rnd();
    host_inst.write_read(OFS_LOW_LIMIT, v, got);
    `CHK("wr_rd", {1'b1, v}, got)
    host_inst.access(1'b1, OFS_LOW_LIMIT, 24'h000010, got);
    result0_word <= 24'h000000;
    result0_valid <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("flag_set", 1'b1, flag)
    result0_valid <= 1'b0;
    rst_n = 0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("rst_flag", 1'b0, flag)
    rst_n = 1;
    host_inst.access(1'b0, OFS_GAIN32, 24'h0, got);
    `CHK("rst_gain", {1'b1, RST_GAIN}, got)
    host_inst.access(1'b0, OFS_LOW_LIMIT, 24'h0, got);
    `CHK("rst_limit", {1'b1, RST_LIMIT}, got)
    v = rnd();
    gain_sel <= GAIN_SEL_8;
    conv_word <= v;
    conv_valid <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("unity", {1'b1, v}, {scaled_valid, scaled_word})
    conv_valid <= 1'b0;
    host_inst.access(1'b1, OFS_GAIN16, 24'h000000, got);
    gain_sel <= 3'(GAIN_SEL_8 + 1);
    conv_valid <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("zero", {1'b1, 24'h000000}, {scaled_valid, scaled_word})
    conv_valid <= 1'b0;
    cal <= '{1'b1, 3'(GAIN_SEL_8 + 3), v};
    fork
      host_inst.access(1'b1, OFS_GAIN64, ~v, got);
      begin
        @(posedge clk);
        #1;
        cal.load <= 1'b0;
      end
    join
    host_inst.access(1'b0, OFS_GAIN64, 24'h0, got);
    `CHK("cal_wins", {1'b1, v}, got)
    complete_run();
  end
endmodule
`default_nettype wire
